/* rtl/opmc_cfg.svh */
// Constants for the operating mode control block
`ifndef OPMC_CFG_SVH
`define OPMC_CFG_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OPMC_OFS_CTRL 8'h00
`define OPMC_OFS_STATUS 8'h04
`define OPMC_OFS_VECTOR 8'h08
// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define OPMC_BIT_STOP_EN 0
`define OPMC_BIT_DBG_EN 1
`define OPMC_BIT_LOWVOLT_EN 2
`define OPMC_BIT_LOWVOLT_STOP_EN 3
`define OPMC_BIT_PWRDN 4
`define OPMC_BIT_REF_KEEP 5
`define OPMC_CTRL_W 6
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OPMC_CTRL_RST 6'h00
`define OPMC_RESET_VECTOR 16'hFFFE
`endif

/* rtl/opmc_pkg.sv */
// Types for the operating mode control block
package opmc_pkg;
  // Operating modes, Gray coded along boot, run, wait, stop path
  typedef enum logic [2:0] {
    OPMC_BOOT = 3'h0,
    OPMC_RUN = 3'h1,
    OPMC_WAIT = 3'h3,
    OPMC_STOP3 = 3'h2,
    OPMC_STOP2 = 3'h6,
    OPMC_ACTBG = 3'h5
  } opmc_mode_e;

  // Serial debug command kinds
  typedef enum logic [2:0] {
    OPMC_CMD_MEM = 3'h0,
    OPMC_CMD_MEM_STAT = 3'h1,
    OPMC_CMD_CTL_REG = 3'h2,
    OPMC_CMD_BACKGROUND = 3'h3,
    OPMC_CMD_CPU_REG = 3'h4,
    OPMC_CMD_TRACE = 3'h5,
    OPMC_CMD_GO = 3'h6
  } opmc_cmd_e;

  // Debug command request
  typedef struct packed {
    logic valid;
    opmc_cmd_e kind;
  } opmc_cmd_s;

  // Debug command answer, one-cycle pulses
  typedef struct packed {
    logic accept;
    logic reject;
    logic err_lowpower;
  } opmc_resp_s;

  // Stop wake sources, levels
  typedef struct packed {
    logic irq_pin;
    logic port_a;
    logic port_b;
    logic port_d;
    logic port_j;
    logic lv_reset;
    logic lv_warn;
    logic adc;
    logic cmp;
    logic rtc;
    logic can;
    logic sci;
  } opmc_wake_s;

  // Clock and power enables
  typedef struct packed {
    logic cpu;
    logic sys;
    logic dbg;
    logic refclk;
    logic regulator;
  } opmc_clk_s;
endpackage : opmc_pkg

/* rtl/opmc_top.sv */
// Operating mode controller with AHB-Lite control registers
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`include "opmc_cfg.svh"

module opmc_top
  import opmc_pkg::*;
(
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Mode strap and CPU events
  input wire logic mode_select_debug_pin,
  input wire logic wait_instr,
  input wire logic stop_instr,
  input wire logic debug_halt_instruction,
  input wire logic bgctl_breakpoint,
  input wire logic dbg_breakpoint,
  input wire logic irq_req,
  input wire opmc_wake_s wake,
  // Debug command port
  input wire opmc_cmd_s cmd,
  output opmc_resp_s resp,
  // Mode, clocks and CPU controls
  output opmc_mode_e mode,
  output opmc_clk_s clk_en,
  output logic state_retain,
  output logic fetch_reset_vec,
  output logic fetch_irq_vec,
  output logic [15:0] fetch_addr,
  output logic clear_imask,
  output logic start_stacking,
  output logic cpu_step,
  output logic illegal_opcode_reset
);

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic [`OPMC_CTRL_W-1:0] ctrl; // Stop and power configuration
  logic wr_pend; // Write data phase pending
  logic [7:0] wr_addr; // Latched write address
  logic addr_ok; // Valid single word address phase
  logic [31:0] rd_mux; // Read value chosen in address phase

  assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'h2);

  // Read mux, unmapped offsets read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (haddr)
      `OPMC_OFS_CTRL: rd_mux = {26'h000_0000, ctrl};
      `OPMC_OFS_STATUS: rd_mux = {24'h00_0000, clk_en, mode};
      `OPMC_OFS_VECTOR: rd_mux = {16'h0000, `OPMC_RESET_VECTOR};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero wait state slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr <= haddr;
      // Data for the read lands as the data phase opens
      if (addr_ok && !hwrite)
        hrdata <= rd_mux;
    end
  end

  // Control register, software steers stop selection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl <= `OPMC_CTRL_RST;
    else if (ce && wr_pend && (wr_addr == `OPMC_OFS_CTRL))
      ctrl <= hwdata[`OPMC_CTRL_W-1:0];
  end

  // ----------------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------------
  logic stop_en; // Stop instruction allowed
  logic dbg_en; // Debug clocks kept in stop
  logic lowvolt_both; // Both detect bits set
  logic any_wake; // Any stop3 wake source
  logic bg_cmd; // Background command arriving
  logic to_halt; // Break into background
  opmc_mode_e next_mode;

  assign stop_en = ctrl[`OPMC_BIT_STOP_EN];
  assign dbg_en = ctrl[`OPMC_BIT_DBG_EN];
  assign lowvolt_both = ctrl[`OPMC_BIT_LOWVOLT_EN] && ctrl[`OPMC_BIT_LOWVOLT_STOP_EN];
  assign any_wake = |wake;
  assign bg_cmd = cmd.valid && (cmd.kind == OPMC_CMD_BACKGROUND);
  assign to_halt = bg_cmd || debug_halt_instruction || bgctl_breakpoint || dbg_breakpoint;

  // Next mode; event priority is debug entry over instructions
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      OPMC_BOOT:
        // Strap is read by this clocked decision after release
        next_mode = mode_select_debug_pin ? OPMC_RUN : OPMC_ACTBG;
      OPMC_RUN:
        if (to_halt)
          next_mode = OPMC_ACTBG;
        else if (wait_instr)
          next_mode = OPMC_WAIT;
        else if (stop_instr && stop_en)
        begin
          if (dbg_en || lowvolt_both || !ctrl[`OPMC_BIT_PWRDN])
            next_mode = OPMC_STOP3;
          else
            next_mode = OPMC_STOP2;
        end
      OPMC_WAIT:
        if (bg_cmd)
          next_mode = OPMC_ACTBG;
        else if (irq_req)
          next_mode = OPMC_RUN;
      OPMC_STOP3:
        if (bg_cmd && dbg_en)
          next_mode = OPMC_ACTBG;
        else if (any_wake)
          next_mode = OPMC_RUN;
      OPMC_STOP2:
        // Only a reset leaves partial power down
        next_mode = OPMC_STOP2;
      OPMC_ACTBG:
        if (cmd.valid && (cmd.kind == OPMC_CMD_GO))
          next_mode = OPMC_RUN;
      default:
        next_mode = OPMC_BOOT;
    endcase
  end

  // Mode register; a reset pin exit of stop3 is this reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode <= OPMC_BOOT;
    else if (ce)
      mode <= next_mode;
  end

  // ----------------------------------------------------------------------
  // Clock and power enables
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_en <= '0;
      state_retain <= 1'b0;
    end
    else if (ce)
    begin
      // CPU runs only in run mode; background keeps it suspended
      clk_en.cpu <= (next_mode == OPMC_RUN);
      clk_en.sys <= (next_mode != OPMC_STOP3) && (next_mode != OPMC_STOP2);
      // Debug logic clocked outside stop, or in stop3 when enabled
      clk_en.dbg <= (next_mode != OPMC_STOP2) && ((next_mode != OPMC_STOP3) || dbg_en);
      clk_en.refclk <= ((next_mode != OPMC_STOP3) && (next_mode != OPMC_STOP2)) ||
                       ctrl[`OPMC_BIT_REF_KEEP];
      // Full regulation outside stop; in stop only if detect or debug on
      clk_en.regulator <= ((next_mode != OPMC_STOP3) && (next_mode != OPMC_STOP2)) ||
                          lowvolt_both || dbg_en;
      state_retain <= (next_mode == OPMC_STOP3);
    end
  end

  // ----------------------------------------------------------------------
  // CPU controls and vector fetch
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fetch_reset_vec <= 1'b0;
      fetch_irq_vec <= 1'b0;
      fetch_addr <= 16'h0000;
      clear_imask <= 1'b0;
      start_stacking <= 1'b0;
      illegal_opcode_reset <= 1'b0;
    end
    else if (ce)
    begin
      // Boot into run, or a low-voltage reset out of stop3
      fetch_reset_vec <= ((mode == OPMC_BOOT) && mode_select_debug_pin) ||
                         ((mode == OPMC_STOP3) && wake.lv_reset &&
                          (next_mode == OPMC_RUN));
      fetch_irq_vec <= (mode == OPMC_STOP3) && (next_mode == OPMC_RUN) &&
                       !wake.lv_reset;
      if (((mode == OPMC_BOOT) && mode_select_debug_pin) ||
          ((mode == OPMC_STOP3) && wake.lv_reset))
        fetch_addr <= `OPMC_RESET_VECTOR;
      clear_imask <= (mode == OPMC_RUN) && (next_mode == OPMC_WAIT);
      start_stacking <= (mode == OPMC_WAIT) && (next_mode == OPMC_RUN);
      // Stop with stop disabled is treated as an illegal opcode
      illegal_opcode_reset <= (mode == OPMC_RUN) && !to_halt && !wait_instr &&
                              stop_instr && !stop_en;
    end
  end

  // ----------------------------------------------------------------------
  // Debug command filter
  // ----------------------------------------------------------------------
  logic nonintr; // Command allowed while user code runs
  logic low_pwr; // Wait or stop mode
  assign nonintr = (cmd.kind == OPMC_CMD_MEM) || (cmd.kind == OPMC_CMD_MEM_STAT) ||
                   (cmd.kind == OPMC_CMD_CTL_REG) || (cmd.kind == OPMC_CMD_BACKGROUND);
  assign low_pwr = (mode == OPMC_WAIT) || (mode == OPMC_STOP3) || (mode == OPMC_STOP2);

  // One answer pulse per command cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      resp <= '0;
      cpu_step <= 1'b0;
    end
    else if (ce)
    begin
      resp <= '0;
      cpu_step <= 1'b0;
      if (cmd.valid)
      begin
        if (low_pwr)
        begin
          // Status reads do no access and flag the low power state
          if (cmd.kind == OPMC_CMD_MEM_STAT)
            resp.err_lowpower <= 1'b1;
          else if (bg_cmd && ((mode == OPMC_WAIT) || ((mode == OPMC_STOP3) && dbg_en)))
            resp.accept <= 1'b1;
          else
            resp.reject <= 1'b1;
        end
        else if (mode == OPMC_ACTBG)
        begin
          resp.accept <= 1'b1;
          cpu_step <= (cmd.kind == OPMC_CMD_TRACE);
        end
        else if ((mode == OPMC_RUN) && nonintr)
          resp.accept <= 1'b1;
        else
          resp.reject <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence wait_entry_s;
    ce && (mode == OPMC_RUN) && !to_halt && wait_instr;
  endsequence

  sequence wait_exit_s;
    ce && (mode == OPMC_WAIT) && !bg_cmd && irq_req;
  endsequence

  strap_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (mode == OPMC_BOOT) && mode_select_debug_pin |=> mode == OPMC_RUN)
    else $error("strap high did not enter run");

  strap_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (mode == OPMC_BOOT) && !mode_select_debug_pin |=> mode == OPMC_ACTBG)
    else $error("strap low did not enter background");

  boot_vector_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (mode == OPMC_BOOT) && mode_select_debug_pin
    |=> fetch_reset_vec && (fetch_addr == 16'hFFFE))
    else $error("run boot missed reset vector");

  halt_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (mode == OPMC_RUN) && debug_halt_instruction |=> mode == OPMC_ACTBG && !clk_en.cpu)
    else $error("halt did not enter background");

  wait_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wait_entry_s |=> clear_imask && !clk_en.cpu && clk_en.sys && mode == OPMC_WAIT)
    else $error("wait entry wrong");

  wait_stack_a: assert property (@(posedge hclk) disable iff (!hresetn)
    wait_exit_s |=> start_stacking && mode == OPMC_RUN)
    else $error("wait exit did not stack");

  lowpwr_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && low_pwr && cmd.valid && (cmd.kind == OPMC_CMD_MEM_STAT)
    |=> resp.err_lowpower && !resp.accept)
    else $error("status command missed low power error");

  run_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (mode == OPMC_RUN) && cmd.valid && !nonintr |=> resp.reject && !resp.accept)
    else $error("active command accepted in run");

  illegal_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (mode == OPMC_RUN) && !to_halt && !wait_instr && stop_instr && !stop_en
    |=> illegal_opcode_reset && mode == OPMC_RUN)
    else $error("disabled stop missed illegal reset");

  stop3_dbg_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (mode == OPMC_RUN) && !to_halt && !wait_instr && stop_instr && stop_en && dbg_en
    |=> mode == OPMC_STOP3 && clk_en.dbg && !clk_en.sys)
    else $error("debug stop not stop3");

  stop_lowvolt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (mode == OPMC_RUN) && !to_halt && !wait_instr && stop_instr && stop_en && lowvolt_both
    |=> mode == OPMC_STOP3 && clk_en.regulator)
    else $error("regulator off with detect enabled");

  stop3_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && (mode == OPMC_STOP3) && any_wake && !(bg_cmd && dbg_en) && !wake.lv_reset
    |=> fetch_irq_vec && mode == OPMC_RUN)
    else $error("stop3 wake missed");

endmodule : opmc_top

/* test/opmc_dbg_host.sv */
// Debug host model: strap level and serial debug commands
`timescale 1ns/100ps
module opmc_dbg_host
  import opmc_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Toward the device
  output opmc_cmd_s cmd,
  output logic mode_select_debug_pin
);
  // Idle bus, strap high
  initial
  begin
    cmd = '0;
    mode_select_debug_pin = 1'b1;
  end

  // Strap level seen when reset is released
  task automatic strap(input logic lvl);
    mode_select_debug_pin <= lvl;
  endtask : strap

  // One command for one cycle; idle kind is inverted so a stale kind never lingers
  task automatic send(input opmc_cmd_e k);
    @(posedge hclk);
    cmd <= '{valid: 1'b1, kind: k};
    @(posedge hclk);
    cmd <= '{valid: 1'b0, kind: opmc_cmd_e'(~k)};
  endtask : send
endmodule : opmc_dbg_host

/* test/tb_operating_mode_control.sv */
// Self-checking bench for the operating mode control block
`timescale 1ns/100ps
`include "opmc_cfg.svh"
`define CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("BAD %s exp %0h got %0h", nm, ex, got); \
    end \
  end

module tb_operating_mode_control
  import opmc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [4:0] ev; // Wait, stop, halt, controller and module breakpoints
  logic irq_req, state_retain, fetch_reset_vec, fetch_irq_vec, clear_imask;
  logic start_stacking, cpu_step, illegal_opcode_reset, pin, s2;
  logic [15:0] fetch_addr;
  logic [11:0] w;
  logic [5:0] c, ctrl;
  logic [5:0] stop_tab [4] = '{6'h03, 6'h1D, 6'h21, 6'h15};
  opmc_wake_s wake;
  opmc_cmd_s cmd;
  opmc_resp_s resp;
  opmc_mode_e mode, cur; // Cur is the bench's own idea of the mode
  opmc_cmd_e k;
  opmc_clk_s clk_en;
  logic [3:0] exp_q [$]; // Expected {accept, reject, err, step}
  logic [3:0] e;
  int failures, n_tests;
  assign hready = hreadyout;

  opmc_top opmc_top_i (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .mode_select_debug_pin(pin),
    .wait_instr(ev[4]), .stop_instr(ev[3]), .debug_halt_instruction(ev[2]),
    .bgctl_breakpoint(ev[1]), .dbg_breakpoint(ev[0]), .irq_req, .wake, .cmd, .resp,
    .mode, .clk_en, .state_retain, .fetch_reset_vec, .fetch_irq_vec, .fetch_addr,
    .clear_imask, .start_stacking, .cpu_step, .illegal_opcode_reset);
  opmc_dbg_host opmc_dbg_host_i (.hclk, .cmd, .mode_select_debug_pin(pin));

  // 100 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Answer watcher: every response pulse takes the oldest note
  always @(posedge hclk)
  begin
    if ((resp.accept | resp.reject | resp.err_lowpower) === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 4'h0;
      `CHK("resp", e, {resp, cpu_step})
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Expected answer for a command in a mode
  function automatic logic [3:0] exp_of(opmc_mode_e m, opmc_cmd_e q, logic dbg);
    logic lowp;
    lowp = (m != OPMC_RUN) && (m != OPMC_ACTBG);
    if (m == OPMC_ACTBG)
      return {3'b100, q == OPMC_CMD_TRACE};
    if (lowp && q == OPMC_CMD_MEM_STAT)
      return 4'b0010;
    if (q == OPMC_CMD_BACKGROUND && (!lowp || m == OPMC_WAIT || (m == OPMC_STOP3 && dbg)))
      return 4'b1000;
    if (lowp || q >= OPMC_CMD_CPU_REG)
      return 4'b0100;
    return 4'b1000;
  endfunction : exp_of

  // Note the answer, send the command, then check the mode
  task automatic dcmd(input opmc_cmd_e q);
    logic [3:0] x; // Own copy; the watcher reuses e at every answer
    x = exp_of(cur, q, ctrl[1]);
    exp_q.push_back(x);
    opmc_dbg_host_i.send(q);
    if (x[3] && q == OPMC_CMD_BACKGROUND)
      cur = OPMC_ACTBG;
    if (x[3] && q == OPMC_CMD_GO)
      cur = OPMC_RUN;
    #1;
    `CHK("cmd mode", cur, mode)
  endtask : dcmd

  // One-cycle CPU event pulse
  task automatic cpu_ev(input int idx);
    @(posedge hclk);
    ev <= 5'h10 >> idx;
    @(posedge hclk);
    ev <= 5'h00;
    #1;
  endtask : cpu_ev

  // One-cycle wake source or interrupt
  task automatic wake_up(input logic [11:0] ww, input logic irq);
    @(posedge hclk);
    wake <= opmc_wake_s'(ww);
    irq_req <= irq;
    @(posedge hclk);
    wake <= '0;
    irq_req <= 1'b0;
    #1;
  endtask : wake_up

  // Single word transfer; waits for ready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : ahb

  // Reset with a strap level, then check the boot outcome
  task automatic do_reset(input logic st);
    // Start on an edge so a pending answer pulse is still seen
    @(posedge hclk);
    hresetn <= 1'b0;
    opmc_dbg_host_i.strap(st);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1;
    cur = st ? OPMC_RUN : OPMC_ACTBG;
    ctrl = 6'h00;
    `CHK("boot mode", cur, mode)
    `CHK("reset fetch", st, fetch_reset_vec)
    `CHK("cpu clock", st, clk_en.cpu)
    if (st)
      `CHK("vector", 16'hFFFE, fetch_addr)
  endtask : do_reset

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // Watchdog, far beyond the expected run length
  initial
  begin
    #100000;
    failures++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ev = 5'h00;
    irq_req = 1'b0;
    wake = '0;
    hresetn = 1'b0;
    rd = $urandom(66);
    // Strap low: every command accepted, GO last returns to run
    do_reset(1'b0);
    for (int i = 0; i < 7; i++)
      dcmd(opmc_cmd_e'(i));
    // Strap high, random commands in run
    do_reset(1'b1);
    repeat (8)
    begin
      k = opmc_cmd_e'(3'($urandom % 7));
      dcmd((k == OPMC_CMD_BACKGROUND) ? OPMC_CMD_MEM : k);
    end
    // Registers: control read back, status, vector, unmapped, read-only write
    rd = $urandom;
    c = rd[5:0];
    ahb(1'b1, `OPMC_OFS_CTRL, rd);
    ahb(1'b0, `OPMC_OFS_CTRL, 32'h0);
    `CHK("ctrl", c, rd[5:0])
    ahb(1'b1, `OPMC_OFS_VECTOR, 32'h0);
    ahb(1'b0, `OPMC_OFS_VECTOR, 32'h0);
    `CHK("vector reg", 32'h0000FFFE, rd)
    ahb(1'b0, `OPMC_OFS_STATUS, 32'h0);
    `CHK("status", {5'h1F, cur}, rd[7:0])
    ahb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    ahb(1'b1, `OPMC_OFS_CTRL, 32'h0);
    // Wait: entry, restricted commands, interrupt exit, command exit
    cpu_ev(0);
    cur = OPMC_WAIT;
    `CHK("wait mode", cur, mode)
    `CHK("imask", 1'b1, clear_imask)
    `CHK("wait clocks", 2'b01, {clk_en.cpu, clk_en.sys})
    dcmd(OPMC_CMD_MEM_STAT);
    dcmd(OPMC_CMD_MEM);
    dcmd(OPMC_CMD_TRACE);
    wake_up(12'h000, 1'b1);
    cur = OPMC_RUN;
    `CHK("irq exit", {1'b1, OPMC_RUN}, {start_stacking, mode})
    cpu_ev(0);
    cur = OPMC_WAIT;
    dcmd(OPMC_CMD_BACKGROUND);
    dcmd(OPMC_CMD_GO);
    // Halt instruction and both breakpoints
    for (int i = 2; i < 5; i++)
    begin
      cpu_ev(i);
      cur = OPMC_ACTBG;
      `CHK("halt mode", {OPMC_ACTBG, 1'b0}, {mode, clk_en.cpu})
      dcmd(OPMC_CMD_GO);
    end
    // Enable low freezes everything: a wait pulse is lost
    @(posedge hclk);
    ce <= 1'b0;
    cpu_ev(0);
    `CHK("frozen", {OPMC_RUN, 1'b0}, {mode, clear_imask})
    @(posedge hclk);
    ce <= 1'b1;
    // Stop while disabled
    cpu_ev(1);
    `CHK("illegal", 1'b1, illegal_opcode_reset)
    do_reset(1'b1);
    // Stop mode selection table and exits
    foreach (stop_tab[i])
    begin
      c = stop_tab[i];
      ahb(1'b1, `OPMC_OFS_CTRL, {26'h0, c});
      ctrl = c;
      cpu_ev(1);
      s2 = !c[1] && !(c[2] && c[3]) && c[4];
      cur = s2 ? OPMC_STOP2 : OPMC_STOP3;
      `CHK("stop mode", cur, mode)
      `CHK("stop clocks", 2'b00, {clk_en.cpu, clk_en.sys})
      `CHK("dbg clock", c[1], clk_en.dbg)
      `CHK("ref clock", c[5], clk_en.refclk)
      `CHK("regulator", c[1] | (c[2] & c[3]), clk_en.regulator)
      `CHK("retain", !s2, state_retain)
      dcmd(OPMC_CMD_MEM_STAT);
      if (s2)
        do_reset(1'b1);
      else if (c[1])
      begin
        dcmd(OPMC_CMD_BACKGROUND);
        dcmd(OPMC_CMD_GO);
      end
      else
      begin
        w = 12'h800 >> ($urandom % 12);
        wake_up(w, 1'b0);
        cur = OPMC_RUN;
        `CHK("wake mode", cur, mode)
        `CHK("wake fetch", {w[6], !w[6]}, {fetch_reset_vec, fetch_irq_vec})
      end
    end
    repeat (3) @(posedge hclk);
    `CHK("notes left", 0, exp_q.size())
    final_report();
  end
endmodule : tb_operating_mode_control
